// ===== core/mdsup_top.sv
`timescale 1ns/1ps
`include "mdsup_map.svh"

module mdsup_top
    import mdsup_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           srst,
    // APB slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic                pready,
    output logic [31:0]         prdata,
    output logic                pslverr,
    // Board controls
    input  wire logic           tick,
    input  wire logic           onOffSwitch,
    input  wire logic           buttonUp,
    input  wire logic           buttonDown,
    output logic                faultLed,
    output logic                statusLed,
    // Coprocessor events
    input  wire logic           ocEvt,
    input  wire mdsup_gex_t     gex,
    input  wire logic           pwmPeriodEvt,
    input  wire logic           serialDoneEvt,
    input  wire logic [31:0]    driveData,
    // Coprocessor commands
    output mdsup_pwm_cmd_t      pwmCmd,
    input  wire mdsup_pwm_rsp_t pwmRsp,
    output logic                faultArmRise,
    output logic [15:0]         speedDemand,
    output logic                initStepReq,
    output logic [2:0]          initStep,
    input  wire logic           initStepAck,
    output logic                sampleTrigPolHigh,
    output logic                queueCopyReq,
    output logic                adcRearmReq
);
    mdsup_state_t   state_q, state_d;
    mdsup_pwm_cmd_t pwmCmd_q;
    logic           switch_q, faultLed_q, statusLed_q, arm_q, pol_q;
    logic [15:0]    speed_q;
    logic [7:0]     step_q;
    logic [31:0]    drive_q, sample_q, prdata_q;
    logic           pready_q, pslverr_q, copy_q, rearm_q, initStart_q;
    logic           gexHit, seqDone, seqReq;
    logic [2:0]     seqIdx;
    logic [3:0]     faultCode;

    function automatic logic [15:0] sat_step(input logic [15:0] v, input logic [7:0] s,
                                             input logic up);
        logic [16:0] t;
        t = up ? {1'b0, v} + {9'h000, s} : {1'b0, v} - {9'h000, s};
        if (t[16])
            sat_step = up ? 16'hffff : 16'h0000;
        else
            sat_step = t[15:0];
    endfunction

    mdsup_fault_cap u_fault (
        .clk         (clk),
        .srst        (srst),
        .ocEvt       (ocEvt),
        .gex         (gex),
        .gexHit      (gexHit),
        .faultCode_q (faultCode)
    );

    mdsup_init_seq u_init (
        .clk       (clk),
        .srst      (srst),
        .start     (initStart_q),
        .stepAck   (initStepAck),
        .stepReq_q (seqReq),
        .stepIdx_q (seqIdx),
        .done_q    (seqDone)
    );

    // Over-current arrives on the coprocessor input channel 4 event line
    wire ocHit      = ocEvt & ~gexHit;
    wire swOn       = tick ? onOffSwitch : switch_q;
    wire inEnable   = state_q == MDS_ENABLE;
    wire inDisable  = state_q == MDS_DISABLE;
    // A late answer to a fault's off command must not count as enable success
    wire pwmOkDone  = pwmRsp.done & pwmRsp.ok & pwmCmd_q.req & (pwmCmd_q.on == inEnable);
    wire clearSpeed = gexHit | ocHit | inEnable | inDisable;

    // Next state; faults preempt everything else
    always_comb
    begin
        state_d = state_q;
        if (gexHit)
            state_d = MDS_GFAULT;
        else if (ocHit)
            state_d = MDS_MFAULT;
        else
        begin
            unique case (state_q)
                MDS_INIT:
                    if (seqDone)
                        state_d = onOffSwitch ? MDS_MFAULT : MDS_STOP;
                MDS_STOP:
                    if (tick && swOn)
                        state_d = MDS_ENABLE;
                MDS_ENABLE:
                    if (pwmOkDone)
                        state_d = MDS_RUN;
                MDS_RUN:
                    if (tick && !swOn)
                        state_d = MDS_DISABLE;
                MDS_DISABLE:
                    if (pwmOkDone)
                        state_d = MDS_STOP;
                MDS_MFAULT:
                    if (tick && !swOn)
                        state_d = MDS_STOP;
                MDS_GFAULT:
                    if (tick && !swOn)
                        state_d = MDS_INIT;
                default:
                    state_d = MDS_INIT;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_q <= MDS_INIT;
        else
            state_q <= state_d;
    end

    // Kick the init sequence on reset release and on each return to init
    always_ff @(posedge clk)
    begin
        if (srst)
            initStart_q <= 1'b1;
        else
            initStart_q <= state_q == MDS_GFAULT && state_d == MDS_INIT;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            switch_q <= 1'b0;
        else if (tick)
            switch_q <= onOffSwitch;
    end

    // PWM command: one request per attempt, retried while the state stays put
    wire pwmIssue = (inEnable | inDisable) & ~pwmCmd_q.req & ~pwmRsp.done;
    always_ff @(posedge clk)
    begin
        if (srst)
            pwmCmd_q <= '0;
        else if (gexHit || ocHit)
            pwmCmd_q <= '{req: 1'b1, on: 1'b0};
        else if (pwmIssue && !(gexHit || ocHit))
            pwmCmd_q <= '{req: 1'b1, on: inEnable};
        else if (pwmRsp.done)
            pwmCmd_q.req <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            arm_q <= 1'b0;
        else if (inEnable && pwmOkDone && !gexHit && !ocEvt)
            arm_q <= 1'b1;
        else if (state_q == MDS_STOP || state_q == MDS_INIT)
            arm_q <= 1'b0;
    end

    // Fault LED stays lit until the motor fault is cleared
    always_ff @(posedge clk)
    begin
        if (srst)
            faultLed_q <= 1'b0;
        else if (ocHit)
            faultLed_q <= 1'b1;
        else if (state_q == MDS_MFAULT && state_d == MDS_STOP)
            faultLed_q <= 1'b0;
    end

    // Status LED: solid in run, blinks per tick in a fault state
    always_ff @(posedge clk)
    begin
        if (srst)
            statusLed_q <= 1'b0;
        else if (tick)
            statusLed_q <= state_q == MDS_RUN ||
                           ((state_q == MDS_MFAULT || state_q == MDS_GFAULT) && !statusLed_q);
    end

    wire apbWr = psel & penable & pwrite;
    wire apbRd = psel & penable & ~pwrite;
    wire hitCtrl   = paddr == `MDS_REG_CTRL;
    wire hitStatus = paddr == `MDS_REG_STATUS;
    wire hitSpeed  = paddr == `MDS_REG_SPEED;
    wire hitDrive  = paddr == `MDS_REG_DRIVE;
    wire hitSample = paddr == `MDS_REG_SAMPLE;
    wire hitFault  = paddr == `MDS_REG_FAULT;
    wire hitAny    = hitCtrl | hitStatus | hitSpeed | hitDrive | hitSample | hitFault;

    // Demand: software writes only count in run; buttons act once per tick
    always_ff @(posedge clk)
    begin
        if (srst)
            speed_q <= `MDS_SPEED_RST;
        else if (clearSpeed)
            speed_q <= `MDS_SPEED_RST;
        else if (state_q == MDS_RUN && apbWr && hitSpeed && !pready_q)
            speed_q <= pwdata[15:0];
        else if (state_q == MDS_RUN && tick && buttonUp != buttonDown)
            speed_q <= sat_step(speed_q, step_q, buttonUp);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            step_q <= `MDS_CTRL_RST;
        else if (apbWr && hitCtrl && !pready_q)
            step_q <= pwdata[`MDS_CTRL_STEP_LSB +: `MDS_CTRL_STEP_W];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            drive_q <= 32'h0000_0000;
        else if (tick)
            drive_q <= driveData;
    end

    // Snapshot at PWM-period resolution on the channel 7 event
    always_ff @(posedge clk)
    begin
        if (srst)
            sample_q <= 32'h0000_0000;
        else if (pwmPeriodEvt)
            sample_q <= {drive_q[15:0], speed_q};
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            pol_q <= 1'b0;
        else if (initStart_q)
            pol_q <= 1'b0;
        else if (seqReq && initStepAck && seqIdx == `MDS_STEP_POL)
            pol_q <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            copy_q  <= 1'b0;
            rearm_q <= 1'b0;
        end
        else
        begin
            copy_q  <= serialDoneEvt;
            rearm_q <= copy_q;
        end
    end

    wire [31:0] statusWord = {23'h000000, pol_q, arm_q, switch_q, statusLed_q, faultLed_q,
                              1'b0, state_q};
    wire [31:0] rdMux = hitCtrl   ? {24'h000000, step_q} :
                        hitStatus ? statusWord :
                        hitSpeed  ? {16'h0000, speed_q} :
                        hitDrive  ? drive_q :
                        hitSample ? sample_q :
                        hitFault  ? {28'h0000000, faultCode} : 32'h0000_0000;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~hitAny;
            prdata_q  <= (apbRd && !pready_q) ? rdMux : 32'h0000_0000;
        end
    end

    assign pready            = pready_q;
    assign pslverr           = pslverr_q;
    assign prdata            = prdata_q;
    assign faultLed          = faultLed_q;
    assign statusLed         = statusLed_q;
    assign pwmCmd            = pwmCmd_q;
    assign faultArmRise      = arm_q;
    assign speedDemand       = speed_q;
    assign initStepReq       = seqReq;
    assign initStep          = seqIdx;
    assign sampleTrigPolHigh = pol_q;
    assign queueCopyReq      = copy_q;
    assign adcRearmReq       = rearm_q;

    a_oc_to_mfault: assert property (@(posedge clk) disable iff (srst)
        ocEvt && !gexHit |=> state_q == MDS_MFAULT && faultLed_q)
        else $error("over-current did not reach motor fault");
    a_gex_to_gfault: assert property (@(posedge clk) disable iff (srst)
        gexHit |=> state_q == MDS_GFAULT && speed_q == 16'h0000)
        else $error("global exception did not reach global fault");
    a_no_direct_link: assert property (@(posedge clk) disable iff (srst)
        state_q == MDS_STOP |=> state_q != MDS_RUN)
        else $error("stop went straight to run");
    a_gfault_exit: assert property (@(posedge clk) disable iff (srst)
        state_q == MDS_GFAULT && $changed(state_q) == 1'b0 ##1 state_q != MDS_GFAULT
        |-> state_q inside {MDS_INIT, MDS_MFAULT})
        else $error("global fault left to a wrong state");
    a_enable_ok: assert property (@(posedge clk) disable iff (srst)
        inEnable && pwmOkDone && !gexHit && !ocEvt |=> state_q == MDS_RUN && arm_q)
        else $error("enable success not followed by run");
    a_disable_hold: assert property (@(posedge clk) disable iff (srst)
        inDisable && !pwmRsp.done && !gexHit && !ocEvt |=> inDisable)
        else $error("disable left without PWM answer");
    a_init_end: assert property (@(posedge clk) disable iff (srst)
        state_q == MDS_INIT && seqDone && !gexHit && !ocEvt
        |=> state_q == ($past(onOffSwitch) ? MDS_MFAULT : MDS_STOP))
        else $error("init exit ignored the switch");
    a_serial_rearm: assert property (@(posedge clk) disable iff (srst)
        serialDoneEvt |=> queueCopyReq ##1 adcRearmReq)
        else $error("serial done not copied and rearmed");
    a_mfault_exit: assert property (@(posedge clk) disable iff (srst)
        state_q == MDS_MFAULT && !tick && !gexHit && !ocEvt |=> state_q == MDS_MFAULT)
        else $error("motor fault left between ticks");
endmodule

// ===== core/mdsup_map.svh
`ifndef MDSUP_MAP_SVH
`define MDSUP_MAP_SVH

// Register byte offsets
`define MDS_REG_CTRL      12'h000
`define MDS_REG_STATUS    12'h004
`define MDS_REG_SPEED     12'h008
`define MDS_REG_DRIVE     12'h00c
`define MDS_REG_SAMPLE    12'h010
`define MDS_REG_FAULT     12'h014

// Control register fields
`define MDS_CTRL_STEP_LSB 0
`define MDS_CTRL_STEP_W   8
`define MDS_CTRL_RST      8'h10

// Status register fields
`define MDS_ST_STATE_LSB  0
`define MDS_ST_FLED_BIT   4
`define MDS_ST_SLED_BIT   5
`define MDS_ST_SWITCH_BIT 6
`define MDS_ST_ARM_BIT    7
`define MDS_ST_POL_BIT    8

// Fault codes
`define MDS_FAULT_NONE    4'h0
`define MDS_FAULT_OVERCUR 4'h1
`define MDS_FAULT_UCODE   4'h2
`define MDS_FAULT_OPCODE  4'h3
`define MDS_FAULT_MISC    4'h4

// Coprocessor channels tied to events
`define MDS_CH_OC_INPUT   4'h4
`define MDS_CH_PWM_MASTER 4'h7

// Init sequence steps
`define MDS_INIT_STEPS    3'h6
`define MDS_STEP_POL      3'h3

`define MDS_SPEED_RST     16'h0000

`endif

// ===== core/mdsup_pkg.sv
package mdsup_pkg;

    typedef enum logic [2:0] {
        MDS_INIT,
        MDS_STOP,
        MDS_ENABLE,
        MDS_RUN,
        MDS_DISABLE,
        MDS_MFAULT,
        MDS_GFAULT
    } mdsup_state_t;

    typedef struct packed {
        logic ucodeExc;
        logic badOpcode;
        logic miscCheck;
    } mdsup_gex_t;

    typedef struct packed {
        logic req;
        logic on;
    } mdsup_pwm_cmd_t;

    typedef struct packed {
        logic done;
        logic ok;
    } mdsup_pwm_rsp_t;

endpackage

// ===== core/mdsup_fault_cap.sv
`timescale 1ns/1ps
`include "mdsup_map.svh"

module mdsup_fault_cap
    import mdsup_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ocEvt,
    input  wire mdsup_gex_t gex,
    output logic            gexHit,
    output logic [3:0]      faultCode_q
);
    logic [3:0] gexCode;

    assign gexHit  = gex.ucodeExc | gex.badOpcode | gex.miscCheck;
    assign gexCode = gex.ucodeExc  ? `MDS_FAULT_UCODE :
                     gex.badOpcode ? `MDS_FAULT_OPCODE : `MDS_FAULT_MISC;

    always_ff @(posedge clk)
    begin
        if (srst)
            faultCode_q <= `MDS_FAULT_NONE;
        else if (gexHit)
            faultCode_q <= gexCode;
        else if (ocEvt)
            faultCode_q <= `MDS_FAULT_OVERCUR;
    end

    a_code_priority: assert property (@(posedge clk) disable iff (srst)
        gexHit && ocEvt |=> faultCode_q != `MDS_FAULT_OVERCUR)
        else $error("over-current code beat a global exception");
endmodule

// ===== core/mdsup_init_seq.sv
`timescale 1ns/1ps
`include "mdsup_map.svh"

module mdsup_init_seq (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       start,
    input  wire logic       stepAck,
    output logic            stepReq_q,
    output logic [2:0]      stepIdx_q,
    output logic            done_q
);
    // Steps are issued one at a time; the far side acknowledges each
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stepReq_q <= 1'b0;
            stepIdx_q <= 3'h0;
            done_q    <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (start)
            begin
                stepReq_q <= 1'b1;
                stepIdx_q <= 3'h0;
            end
            else if (stepReq_q && stepAck)
            begin
                if (stepIdx_q == `MDS_INIT_STEPS - 3'h1)
                begin
                    stepReq_q <= 1'b0;
                    done_q    <= 1'b1;
                end
                else
                    stepIdx_q <= stepIdx_q + 3'h1;
            end
        end
    end

    a_steps_in_order: assert property (@(posedge clk) disable iff (srst)
        stepReq_q && stepAck && !start && stepIdx_q != `MDS_INIT_STEPS - 3'h1
        |=> stepIdx_q == $past(stepIdx_q) + 3'h1)
        else $error("init step skipped or repeated");
endmodule

// ===== tb/mdsup_copro_model.sv
`timescale 1ns/1ps

module mdsup_copro_model
    import mdsup_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           srst,
    input  wire mdsup_pwm_cmd_t pwmCmd,
    input  wire logic           initStepReq,
    input  wire logic [3:0]     dly,
    input  wire logic           refuse,
    output mdsup_pwm_rsp_t      pwmRsp,
    output logic                initStepAck,
    output logic                pwmPeriodEvt,
    output logic                serialDoneEvt
);
    logic [3:0] pwmCnt_q;
    logic [3:0] initCnt_q;
    logic [4:0] perCnt_q;

    // Single-cycle done, so one request never gets two answers
    always_ff @(posedge clk)
    begin
        if (srst || !pwmCmd.req || pwmRsp.done)
        begin
            pwmCnt_q <= 4'h0;
            pwmRsp   <= '0;
        end
        else if (pwmCnt_q == dly)
            pwmRsp   <= {1'b1, !refuse};
        else
            pwmCnt_q <= pwmCnt_q + 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (srst || !initStepReq || initStepAck)
        begin
            initCnt_q   <= 4'h0;
            initStepAck <= 1'b0;
        end
        else if (initCnt_q == dly)
            initStepAck <= 1'b1;
        else
            initCnt_q   <= initCnt_q + 4'h1;
    end

    // Period master event, serial completion follows each period
    always_ff @(posedge clk)
    begin
        if (srst)
            perCnt_q <= 5'h00;
        else
            perCnt_q <= (perCnt_q == 5'h13) ? 5'h00 : perCnt_q + 5'h01;
        pwmPeriodEvt  <= !srst && perCnt_q == 5'h13;
        serialDoneEvt <= !srst && perCnt_q == 5'h05;
    end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "mdsup_map.svh"

module testbench;
    import mdsup_pkg::*;

    logic           clk = 1'b0;
    logic           srst = 1'b1;
    logic           psel, penable, pwrite, pready, pslverr, tick, onOffSwitch, ocEvt, refuse;
    logic           faultLed, statusLed, pwmPeriodEvt, serialDoneEvt, faultArmRise;
    logic           initStepReq, initStepAck, sampleTrigPolHigh, queueCopyReq, adcRearmReq;
    logic           err, sdPrev, qcPrev, buttonUp, buttonDown;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, driveData, rd, wv;
    logic [15:0]    speedDemand;
    logic [2:0]     initStep, expStep;
    logic [3:0]     dly;
    mdsup_gex_t     gex, g;
    mdsup_pwm_cmd_t pwmCmd;
    mdsup_pwm_rsp_t pwmRsp;
    int             n_fail, checks, seed;

    always #50 clk = ~clk;

    mdsup_top u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .tick(tick), .onOffSwitch(onOffSwitch), .buttonUp(buttonUp), .buttonDown(buttonDown),
        .faultLed(faultLed), .statusLed(statusLed), .ocEvt(ocEvt), .gex(gex),
        .pwmPeriodEvt(pwmPeriodEvt), .serialDoneEvt(serialDoneEvt), .driveData(driveData),
        .pwmCmd(pwmCmd), .pwmRsp(pwmRsp), .faultArmRise(faultArmRise),
        .speedDemand(speedDemand), .initStepReq(initStepReq), .initStep(initStep),
        .initStepAck(initStepAck), .sampleTrigPolHigh(sampleTrigPolHigh),
        .queueCopyReq(queueCopyReq), .adcRearmReq(adcRearmReq));

    mdsup_copro_model u_copro (.clk(clk), .srst(srst), .pwmCmd(pwmCmd),
        .initStepReq(initStepReq), .dly(dly), .refuse(refuse), .pwmRsp(pwmRsp),
        .initStepAck(initStepAck), .pwmPeriodEvt(pwmPeriodEvt),
        .serialDoneEvt(serialDoneEvt));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Request stands until pready is seen high at a rising edge; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic doTick;
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic evt(input mdsup_gex_t ge, input logic oc);
        @(posedge clk);
        gex   <= ge;
        ocEvt <= oc;
        @(posedge clk);
        gex   <= '0;
        ocEvt <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic stChk(input mdsup_state_t s);
        apb(1'b0, `MDS_REG_STATUS, 32'h0);
        chk({29'h0, rd[2:0]}, {29'h0, s});
    endtask

    // Ticks keep the machine moving while polling
    task automatic goSt(input mdsup_state_t s);
        for (int i = 0; i < 40; i++)
        begin
            apb(1'b0, `MDS_REG_STATUS, 32'h0);
            if (rd[2:0] === s)
                break;
            doTick();
        end
        chk({29'h0, rd[2:0]}, {29'h0, s});
    endtask

    function automatic logic [3:0] expCode(input mdsup_gex_t ge);
        if (ge.ucodeExc) return `MDS_FAULT_UCODE;
        if (ge.badOpcode) return `MDS_FAULT_OPCODE;
        return `MDS_FAULT_MISC;
    endfunction

    // One button step from the reset step size, clipped at both ends
    function automatic logic [15:0] expBtn(input logic [15:0] v, input logic up);
        if (up)
            return (v > 16'hffff - 16'(`MDS_CTRL_RST)) ? 16'hffff : v + 16'(`MDS_CTRL_RST);
        return (v < 16'(`MDS_CTRL_RST)) ? 16'h0000 : v - 16'(`MDS_CTRL_RST);
    endfunction

    always @(negedge clk)
    begin
        if (srst)
        begin
            expStep = 3'h0;
            sdPrev = 1'b0;
            qcPrev = 1'b0;
        end
        else
        begin
            if (initStepReq && initStepAck)
            begin
                chk(initStep, expStep);
                chk(sampleTrigPolHigh, expStep > `MDS_STEP_POL);
                expStep = (expStep == 3'h5) ? 3'h0 : expStep + 3'h1;
            end
            chk(queueCopyReq, sdPrev);
            chk(adcRearmReq, qcPrev);
            sdPrev = serialDoneEvt;
            qcPrev = queueCopyReq;
        end
    end

    initial
    begin
        seed = 32'hd4e9;
        {psel, penable, pwrite, tick, onOffSwitch, ocEvt, refuse, buttonUp, buttonDown} = '0;
        {paddr, pwdata, driveData} = '0;
        gex = '0;
        dly = 4'h4;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        stChk(MDS_INIT);
        goSt(MDS_STOP);
        apb(1'b0, `MDS_REG_CTRL, 32'h0);
        chk(rd, {24'h0, `MDS_CTRL_RST});
        apb(1'b0, 12'h0f0, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, `MDS_REG_SPEED, 32'h1234);
        chk(speedDemand, `MDS_SPEED_RST);
        $display("reset test done");
        for (int k = 0; k < 4; k++)
        begin
            dly <= 4'($random(seed));
            refuse <= (k == 1);
            onOffSwitch <= 1'b1;
            doTick();
            if (k == 1)
            begin
                repeat (30) @(posedge clk);
                stChk(MDS_ENABLE);
                refuse <= 1'b0;
            end
            goSt(MDS_RUN);
            chk(faultArmRise, 1'b1);
            wv = $random(seed);
            apb(1'b1, `MDS_REG_SPEED, wv);
            chk(speedDemand, wv[15:0]);
            driveData <= $random(seed);
            doTick();
            apb(1'b0, `MDS_REG_DRIVE, 32'h0);
            chk(rd, driveData);
            chk(statusLed, 1'b1);
            repeat (25) @(posedge clk);
            apb(1'b0, `MDS_REG_SAMPLE, 32'h0);
            chk(rd, {driveData[15:0], wv[15:0]});
            buttonUp   <= k[0];
            buttonDown <= !k[0];
            doTick();
            chk(speedDemand, expBtn(wv[15:0], k[0]));
            buttonUp   <= 1'b0;
            buttonDown <= 1'b0;
            onOffSwitch <= 1'b0;
            refuse <= (k == 2);
            doTick();
            if (k == 2)
            begin
                repeat (30) @(posedge clk);
                stChk(MDS_DISABLE);
                refuse <= 1'b0;
            end
            goSt(MDS_STOP);
            chk(speedDemand, 32'h0);
        end
        $display("on off test done");
        dly <= 4'h6;
        onOffSwitch <= 1'b1;
        goSt(MDS_RUN);
        evt('0, 1'b1);
        stChk(MDS_MFAULT);
        chk(faultLed, 1'b1);
        chk(speedDemand, 32'h0);
        chk(pwmCmd.on, 1'b0);
        apb(1'b0, `MDS_REG_FAULT, 32'h0);
        chk(rd, {28'h0, `MDS_FAULT_OVERCUR});
        doTick();
        stChk(MDS_MFAULT);
        onOffSwitch <= 1'b0;
        goSt(MDS_STOP);
        chk(faultLed, 1'b0);
        evt('0, 1'b1);
        stChk(MDS_MFAULT);
        goSt(MDS_STOP);
        $display("overcurrent test done");
        for (int k = 0; k < 6; k++)
        begin
            g = (k < 3) ? (3'b100 >> k) : 3'($random(seed));
            if (g == 3'b000)
                g = 3'b011;
            onOffSwitch <= 1'b1;
            goSt(MDS_RUN);
            evt(g, k == 5);
            stChk(MDS_GFAULT);
            apb(1'b0, `MDS_REG_FAULT, 32'h0);
            chk(rd, {28'h0, expCode(g)});
            chk(speedDemand, 32'h0);
            doTick();
            stChk(MDS_GFAULT);
            onOffSwitch <= 1'b0;
            doTick();
            onOffSwitch <= (k == 4);
            stChk(MDS_INIT);
            if (k == 4)
            begin
                goSt(MDS_MFAULT);
                onOffSwitch <= 1'b0;
            end
            goSt(MDS_STOP);
        end
        $display("global fault test done");
        stop_test();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        n_fail++;
        stop_test();
    end
endmodule
